/* File: core/bcltd_top.sv */
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/10ps
module bcltd_top
(
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic [15:0] INSTR,
	input wire logic INSTR_VALID,
	input wire logic [7:0] FILE_RDATA,
	input wire logic [7:0] PORT_PINS,
	input wire logic PRESCALER_TO_TIMER_ZERO_COUNTER,
	output logic [7:0] FILE_ADDR,
	output logic FILE_ACCESS_BANK,
	output logic [7:0] FILE_WDATA,
	output logic FILE_WE,
	output logic PRESCALER_CLR,
	output logic PC_LOAD,
	output logic [20:0] PC_TARGET,
	output logic PC_REL,
	output logic [10:0] PC_OFFSET,
	output logic SKIP,
	output logic STALL,
	output logic STACK_PUSH,
	output logic STACK_POP,
	output logic FAST_SAVE,
	output logic FAST_RESTORE,
	output logic [7:0] WORKING_REGISTER,
	output logic [3:0] BANK_SELECT_REGISTER,
	output logic [1:0] PTR_SEL,
	output logic [11:0] INDIRECT_POINTER,
	output logic PTR_LOAD,
	output logic TBL_READ,
	output logic TBL_WRITE,
	output logic [1:0] TBL_MODE,
	output logic [15:0] PRODUCT,
	output logic CARRY_FLAG,
	output logic DIGIT_CARRY_FLAG,
	output logic ZERO_FLAG,
	output logic OVERFLOW_FLAG,
	output logic NEGATIVE_FLAG,
	output logic TIMEOUT_FLAG,
	output logic POWER_DOWN_FLAG,
	output logic GLOBAL_INTERRUPT_ENABLE,
	output logic PERIPHERAL_LOW_INTERRUPT_ENABLE,
	output logic WATCHDOG_CLEAR,
	output logic STANDBY,
	output logic SOFT_RESET
);
	typedef enum logic [1:0] {BCL_EXEC, BCL_NOPC, BCL_WORD2} bcltd_state_t;
	bcltd_state_t state_r;
	logic [7:0] pin1_r;
	logic [7:0] pin2_r;
	logic [3:0] hi;
	logic [3:0] sub;
	logic [7:0] lo;
	logic [7:0] kw1_r;
	logic [3:0] first_r;
	logic rst_all;
	logic is_port;
	logic [7:0] bit_res;
	logic bit_val;
	logic [1:0] bop;
	logic [2:0] alu_op;
	logic [7:0] alu_res;
	logic alu_c;
	logic alu_dc;
	logic alu_ov;
	logic cond;
	logic is_two;
	logic exec;
	logic zeros;
	logic pend_skip_r;

	assign hi = INSTR[15:12];
	assign sub = INSTR[11:8];
	assign lo = INSTR[7:0];
	assign exec = INSTR_VALID && state_r == BCL_EXEC;
	assign zeros = hi == bcltd_pkg::OP_ZERO && sub == 4'h0;
	assign is_port = lo >= bcltd_pkg::PORT_LO && lo <= bcltd_pkg::PORT_HI;
	assign is_two = hi == bcltd_pkg::OP_BRC && (sub == bcltd_pkg::BR_CALL
		|| sub == {bcltd_pkg::BR_CALL[3:1], 1'b1}
		|| sub == bcltd_pkg::BR_PLOAD || sub == bcltd_pkg::BR_GOTO);

	// Two-stage sync: pins are asynchronous to the core clock
	always_ff @(posedge REF_CLK)
	begin
		pin1_r <= PORT_PINS;
		pin2_r <= pin1_r;
	end

	always_comb
	begin
		case (hi)
			bcltd_pkg::OP_BCLR: bop = 2'(bcltd_pkg::BCL_CLR);
			bcltd_pkg::OP_BSET: bop = 2'(bcltd_pkg::BCL_SET);
			bcltd_pkg::OP_BTOG: bop = 2'(bcltd_pkg::BCL_TOG);
			default: bop = 2'(bcltd_pkg::BCL_NONE);
		endcase
	end

	bcltd_bitop u_bitop
	(
		.op(bop),
		.idx(INSTR[11:9]),
		.latch_val(FILE_RDATA),
		.pin_val(pin2_r),
		.is_port(is_port),
		.res(bit_res),
		.bit_val(bit_val)
	);

	always_comb
	begin
		alu_op = 3'(bcltd_pkg::ALU_NONE);
		if (hi == bcltd_pkg::OP_ZERO)
		begin
			case (sub)
				bcltd_pkg::LIT_ADD: alu_op = 3'(bcltd_pkg::ALU_ADD);
				bcltd_pkg::LIT_SUB: alu_op = 3'(bcltd_pkg::ALU_SUB);
				bcltd_pkg::LIT_AND: alu_op = 3'(bcltd_pkg::ALU_AND);
				bcltd_pkg::LIT_IOR: alu_op = 3'(bcltd_pkg::ALU_IOR);
				bcltd_pkg::LIT_XOR: alu_op = 3'(bcltd_pkg::ALU_XOR);
				bcltd_pkg::LIT_MOV: alu_op = 3'(bcltd_pkg::ALU_MOV);
				bcltd_pkg::LIT_RET: alu_op = 3'(bcltd_pkg::ALU_MOV);
				4'h0:
					if (lo == bcltd_pkg::INH_DAW)
						alu_op = 3'(bcltd_pkg::ALU_DAW);
				default: alu_op = 3'(bcltd_pkg::ALU_NONE);
			endcase
		end
	end

	bcltd_alu u_alu
	(
		.op(alu_op),
		.w(WORKING_REGISTER),
		.k(lo),
		.c_in(CARRY_FLAG),
		.dc_in(DIGIT_CARRY_FLAG),
		.res(alu_res),
		.c(alu_c),
		.dc(alu_dc),
		.ov(alu_ov)
	);

	always_comb
	begin
		case (sub)
			4'h0: cond = ZERO_FLAG;
			4'h1: cond = !ZERO_FLAG;
			4'h2: cond = CARRY_FLAG;
			4'h3: cond = !CARRY_FLAG;
			4'h4: cond = OVERFLOW_FLAG;
			4'h5: cond = !OVERFLOW_FLAG;
			4'h6: cond = NEGATIVE_FLAG;
			4'h7: cond = !NEGATIVE_FLAG;
			default: cond = 1'b0;
		endcase
	end

	// Sequencer: extra cycles are idle slots, first-word fields are captured for the second word
	always_ff @(posedge REF_CLK)
	begin
		if (rst_all)
		begin
			state_r <= BCL_EXEC;
			kw1_r <= 8'h00;
			first_r <= 4'h0;
			pend_skip_r <= 1'b0;
		end
		else if (INSTR_VALID)
		begin
			case (state_r)
				BCL_EXEC:
				begin
					kw1_r <= lo;
					first_r <= sub;
					if (pend_skip_r)
					begin
						// skipped word; two-word target costs one more
						pend_skip_r <= 1'b0;
						state_r <= is_two ? BCL_NOPC : BCL_EXEC;
					end
					else if (is_two)
						state_r <= BCL_WORD2;
					else if ((hi == bcltd_pkg::OP_SKC && !bit_val)
						|| (hi == bcltd_pkg::OP_SKS && bit_val))
						pend_skip_r <= 1'b1;
					else if (hi == bcltd_pkg::OP_REL
						|| (hi == bcltd_pkg::OP_BRC && !sub[3] && cond)
						|| (hi == bcltd_pkg::OP_ZERO && sub == bcltd_pkg::LIT_RET)
						|| (zeros && (lo[7:1] == bcltd_pkg::INH_INTERRUPT_RETURN_OP
						|| lo[7:1] == bcltd_pkg::INH_RETURN
						|| lo[7:2] == bcltd_pkg::INH_TABLE_READ_OP
						|| lo[7:2] == bcltd_pkg::INH_TABLE_WRITE_OP)))
						state_r <= BCL_NOPC;
				end
				BCL_WORD2: state_r <= BCL_EXEC;
				BCL_NOPC: state_r <= BCL_EXEC;
				default: state_r <= BCL_EXEC;
			endcase
		end
	end
	// Decoded software reset restarts every register of the block except the two pin sync stages
	assign rst_all = RST || SOFT_RESET;

	// Register file and bit-modify path
	always_ff @(posedge REF_CLK)
	begin
		if (rst_all)
		begin
			FILE_ADDR <= 8'h00;
			FILE_ACCESS_BANK <= 1'b0;
			FILE_WDATA <= 8'h00;
			FILE_WE <= 1'b0;
			PRESCALER_CLR <= 1'b0;
		end
		else
		begin
			FILE_ADDR <= lo;
			FILE_ACCESS_BANK <= INSTR[8];
			FILE_WDATA <= bit_res;
			FILE_WE <= exec && !pend_skip_r && bop != 2'h0;
			PRESCALER_CLR <= exec && !pend_skip_r && bop != 2'h0
				&& lo == bcltd_pkg::TIMER_ZERO_COUNTER_ADDR && PRESCALER_TO_TIMER_ZERO_COUNTER;
		end
	end

	// Control flow strobes
	always_ff @(posedge REF_CLK)
	begin
		if (rst_all)
		begin
			PC_LOAD <= 1'b0;
			PC_TARGET <= 21'h00000;
			PC_REL <= 1'b0;
			PC_OFFSET <= 11'h000;
			SKIP <= 1'b0;
			STALL <= 1'b0;
			STACK_PUSH <= 1'b0;
			STACK_POP <= 1'b0;
			FAST_SAVE <= 1'b0;
			FAST_RESTORE <= 1'b0;
			GLOBAL_INTERRUPT_ENABLE <= 1'b0;
			PERIPHERAL_LOW_INTERRUPT_ENABLE <= 1'b0;
		end
		else
		begin
			PC_LOAD <= 1'b0;
			PC_REL <= 1'b0;
			SKIP <= INSTR_VALID && state_r == BCL_EXEC && pend_skip_r;
			STALL <= INSTR_VALID && state_r != BCL_EXEC;
			STACK_PUSH <= 1'b0;
			STACK_POP <= 1'b0;
			FAST_SAVE <= 1'b0;
			FAST_RESTORE <= 1'b0;
			if (exec && !pend_skip_r)
			begin
				if (hi == bcltd_pkg::OP_REL)
				begin
					PC_REL <= 1'b1;
					PC_OFFSET <= INSTR[10:0];
					STACK_PUSH <= INSTR[11];
				end
				else if (hi == bcltd_pkg::OP_BRC && !sub[3] && cond)
				begin
					PC_REL <= 1'b1;
					PC_OFFSET <= {{3{lo[7]}}, lo};
				end
				else if (hi == bcltd_pkg::OP_ZERO
					&& sub == bcltd_pkg::LIT_RET)
					STACK_POP <= 1'b1;
				else if (zeros && lo == bcltd_pkg::INH_PUSH)
					STACK_PUSH <= 1'b1;
				else if (zeros && lo == bcltd_pkg::INH_POP)
					STACK_POP <= 1'b1;
				else if (zeros && (lo[7:1] == bcltd_pkg::INH_INTERRUPT_RETURN_OP
					|| lo[7:1] == bcltd_pkg::INH_RETURN))
				begin
					STACK_POP <= 1'b1;
					FAST_RESTORE <= lo[0];
					if (lo[7:1] == bcltd_pkg::INH_INTERRUPT_RETURN_OP)
					begin
						GLOBAL_INTERRUPT_ENABLE <= 1'b1;
						PERIPHERAL_LOW_INTERRUPT_ENABLE <= 1'b1;
					end
				end
			end
			else if (INSTR_VALID && state_r == BCL_WORD2
				&& hi == bcltd_pkg::OP_SEC)
			begin
				if (first_r[3:1] == bcltd_pkg::BR_CALL[3:1])
				begin
					PC_LOAD <= 1'b1;
					STACK_PUSH <= 1'b1;
					FAST_SAVE <= first_r[0];
					PC_TARGET <= {INSTR[11:0], kw1_r, 1'b0};
				end
				else if (first_r == bcltd_pkg::BR_GOTO)
				begin
					PC_LOAD <= 1'b1;
					PC_TARGET <= {INSTR[11:0], kw1_r, 1'b0};
				end
			end
		end
	end

	// Working register, pointers, table and flags
	always_ff @(posedge REF_CLK)
	begin
		if (rst_all)
		begin
			WORKING_REGISTER <= 8'h00;
			BANK_SELECT_REGISTER <= 4'h0;
			PTR_SEL <= 2'h0;
			INDIRECT_POINTER <= 12'h000;
			PTR_LOAD <= 1'b0;
			TBL_READ <= 1'b0;
			TBL_WRITE <= 1'b0;
			TBL_MODE <= bcltd_pkg::PTR_NONE;
			PRODUCT <= 16'h0000;
			CARRY_FLAG <= 1'b0;
			DIGIT_CARRY_FLAG <= 1'b0;
			ZERO_FLAG <= 1'b0;
			OVERFLOW_FLAG <= 1'b0;
			NEGATIVE_FLAG <= 1'b0;
			TIMEOUT_FLAG <= 1'b1;
			POWER_DOWN_FLAG <= 1'b1;
			WATCHDOG_CLEAR <= 1'b0;
			STANDBY <= 1'b0;
			SOFT_RESET <= 1'b0;
		end
		else
		begin
			PTR_LOAD <= 1'b0;
			TBL_READ <= 1'b0;
			TBL_WRITE <= 1'b0;
			WATCHDOG_CLEAR <= 1'b0;
			STANDBY <= 1'b0;
			SOFT_RESET <= 1'b0;
			if (exec && !pend_skip_r)
			begin
				if (alu_op != 3'(bcltd_pkg::ALU_NONE))
					WORKING_REGISTER <= alu_res;
				if (alu_op == 3'(bcltd_pkg::ALU_ADD)
					|| alu_op == 3'(bcltd_pkg::ALU_SUB))
				begin
					CARRY_FLAG <= alu_c;
					DIGIT_CARRY_FLAG <= alu_dc;
					OVERFLOW_FLAG <= alu_ov;
				end
				if (alu_op == 3'(bcltd_pkg::ALU_DAW))
					CARRY_FLAG <= alu_c;
				if (alu_op == 3'(bcltd_pkg::ALU_ADD)
					|| alu_op == 3'(bcltd_pkg::ALU_SUB)
					|| alu_op == 3'(bcltd_pkg::ALU_AND)
					|| alu_op == 3'(bcltd_pkg::ALU_IOR)
					|| alu_op == 3'(bcltd_pkg::ALU_XOR))
				begin
					ZERO_FLAG <= alu_res == 8'h00;
					NEGATIVE_FLAG <= alu_res[7];
				end
				if (hi == bcltd_pkg::OP_ZERO && sub == bcltd_pkg::LIT_MUL)
					PRODUCT <= {8'h00, WORKING_REGISTER} * {8'h00, lo};
				if (hi == bcltd_pkg::OP_ZERO && sub == bcltd_pkg::LIT_BANK
					&& lo[7:4] == 4'h0)
					BANK_SELECT_REGISTER <= lo[3:0];
				if (hi == bcltd_pkg::OP_BRC && sub == bcltd_pkg::BR_PLOAD)
					PTR_SEL <= lo[5:4];
				if (zeros && lo[7:2] == bcltd_pkg::INH_TABLE_READ_OP)
				begin
					TBL_READ <= 1'b1;
					TBL_MODE <= lo[1:0];
				end
				if (zeros && lo[7:2] == bcltd_pkg::INH_TABLE_WRITE_OP)
				begin
					TBL_WRITE <= 1'b1;
					TBL_MODE <= lo[1:0];
				end
				if (zeros && lo == bcltd_pkg::INH_WATCHDOG_CLEAR_OP)
				begin
					WATCHDOG_CLEAR <= 1'b1;
					TIMEOUT_FLAG <= 1'b1;
					POWER_DOWN_FLAG <= 1'b1;
				end
				if (zeros && lo == bcltd_pkg::INH_SLEEP)
				begin
					STANDBY <= 1'b1;
					TIMEOUT_FLAG <= 1'b1;
					POWER_DOWN_FLAG <= 1'b0;
				end
				if (zeros && lo == bcltd_pkg::INH_RESET)
					SOFT_RESET <= 1'b1;
			end
			else if (INSTR_VALID && state_r == BCL_WORD2
				&& hi == bcltd_pkg::OP_SEC && first_r == bcltd_pkg::BR_PLOAD
				&& sub == 4'h0)
			begin
				INDIRECT_POINTER <= {kw1_r[3:0], lo};
				PTR_LOAD <= 1'b1;
			end
		end
	end
endmodule

/* File: include/bcltd_pkg.sv */
// Functional notes
// - Bit clear/set/toggle from top nibbles 1001/1000/0111, one cycle, no flags.
// - Skip-if-clear 1011, skip-if-set 1010; skip adds one or two cycles.
// - Conditional branch 1110 plus condition code, 8-bit offset; taken costs two.
// - Program counter changes take two cycles, the second a no-operation.
// - Absolute call is two words, fast-save bit, 20-bit target.
// - Absolute jump 1110 1111 is two words, 20-bit target.
// - A lone 1111 word runs as no-operation; consumed only by a first word.
// - Inherent ops: nop, standby, watchdog clear, decimal adjust, software reset.
// - Push and pop of return stack top, one cycle, no flags.
// - Interrupt and subroutine return take two cycles; interrupt return re-enables.
// - Literal return loads working register and returns in two cycles.
// - Literal and/or/xor with working register update zero and negative only.
// - Literal add and subtract update carry, digit carry, zero, overflow, negative.
// - Literal move and multiply change no flags.
// - Bank load writes 4-bit literal into low bank select bits.
// - Pointer load is two words forming a 12-bit literal.
// - Table reads 10xx take two cycles with four pointer modes.
// - Table writes 11xx take two cycles with the same pointer modes.
// - Port bit-modify reads the pins, not the output latch.
// - Bit-modify write to timer zero clears its assigned prescaler.
package bcltd_pkg;
	localparam logic [3:0] OP_BCLR = 4'h9;
	localparam logic [3:0] OP_BSET = 4'h8;
	localparam logic [3:0] OP_BTOG = 4'h7;
	localparam logic [3:0] OP_SKC = 4'hb;
	localparam logic [3:0] OP_SKS = 4'ha;
	localparam logic [3:0] OP_BRC = 4'he;
	localparam logic [3:0] OP_REL = 4'hd;
	localparam logic [3:0] OP_SEC = 4'hf;
	localparam logic [3:0] OP_ZERO = 4'h0;
	localparam logic [3:0] LIT_ADD = 4'hf;
	localparam logic [3:0] LIT_AND = 4'hb;
	localparam logic [3:0] LIT_IOR = 4'h9;
	localparam logic [3:0] LIT_XOR = 4'ha;
	localparam logic [3:0] LIT_SUB = 4'h8;
	localparam logic [3:0] LIT_MOV = 4'he;
	localparam logic [3:0] LIT_MUL = 4'hd;
	localparam logic [3:0] LIT_RET = 4'hc;
	localparam logic [3:0] LIT_BANK = 4'h1;
	localparam logic [3:0] BR_CALL = 4'hc;
	localparam logic [3:0] BR_PLOAD = 4'he;
	localparam logic [3:0] BR_GOTO = 4'hf;
	localparam logic [7:0] INH_NOP = 8'h00;
	localparam logic [7:0] INH_SLEEP = 8'h03;
	localparam logic [7:0] INH_WATCHDOG_CLEAR_OP = 8'h04;
	localparam logic [7:0] INH_PUSH = 8'h05;
	localparam logic [7:0] INH_POP = 8'h06;
	localparam logic [7:0] INH_DAW = 8'h07;
	localparam logic [6:0] INH_INTERRUPT_RETURN_OP = 7'h08;
	localparam logic [6:0] INH_RETURN = 7'h09;
	localparam logic [5:0] INH_TABLE_READ_OP = 6'h02;
	localparam logic [5:0] INH_TABLE_WRITE_OP = 6'h03;
	localparam logic [7:0] INH_RESET = 8'hff;
	localparam logic [1:0] PTR_NONE = 2'h0;
	localparam logic [1:0] PTR_POSTINC = 2'h1;
	localparam logic [1:0] PTR_POSTDEC = 2'h2;
	localparam logic [1:0] PTR_PREINC = 2'h3;
	localparam logic [7:0] PORT_LO = 8'h80;
	localparam logic [7:0] PORT_HI = 8'h82;
	localparam logic [7:0] TIMER_ZERO_COUNTER_ADDR = 8'hd6;
	typedef enum logic [1:0] {BCL_NONE, BCL_CLR, BCL_SET, BCL_TOG} bcltd_bitop_t;
	typedef enum logic [2:0] {ALU_NONE, ALU_ADD, ALU_SUB, ALU_AND,
		ALU_IOR, ALU_XOR, ALU_MOV, ALU_DAW} bcltd_alu_t;
endpackage

/* File: core/bcltd_alu.sv */
`timescale 1ns/10ps
module bcltd_alu
(
	input wire logic [2:0] op,
	input wire logic [7:0] w,
	input wire logic [7:0] k,
	input wire logic c_in,
	input wire logic dc_in,
	output logic [7:0] res,
	output logic c,
	output logic dc,
	output logic ov
);
	logic [8:0] s;
	logic [4:0] h;
	logic [8:0] d;
	always_comb
	begin
		s = 9'h000;
		h = 5'h00;
		d = {1'b0, w};
		res = w;
		c = c_in;
		dc = dc_in;
		ov = 1'b0;
		case (bcltd_pkg::bcltd_alu_t'(op))
			bcltd_pkg::ALU_ADD:
			begin
				s = {1'b0, w} + {1'b0, k};
				h = {1'b0, w[3:0]} + {1'b0, k[3:0]};
				res = s[7:0];
				c = s[8];
				dc = h[4];
				ov = (w[7] == k[7]) && (s[7] != w[7]);
			end
			bcltd_pkg::ALU_SUB:
			begin
				s = {1'b0, k} + {1'b0, ~w} + 9'h001;
				h = {1'b0, k[3:0]} + {1'b0, ~w[3:0]} + 5'h01;
				res = s[7:0];
				c = s[8];
				dc = h[4];
				ov = (k[7] != w[7]) && (s[7] != k[7]);
			end
			bcltd_pkg::ALU_AND: res = w & k;
			bcltd_pkg::ALU_IOR: res = w | k;
			bcltd_pkg::ALU_XOR: res = w ^ k;
			bcltd_pkg::ALU_MOV: res = k;
			bcltd_pkg::ALU_DAW:
			begin
				if (w[3:0] > 4'h9 || dc_in)
					d = d + 9'h006;
				if (d[7:4] > 4'h9 || c_in || d[8])
					d = d + 9'h060;
				res = d[7:0];
				c = d[8] | c_in;
			end
			default: res = w;
		endcase
	end
endmodule

/* File: core/bcltd_bitop.sv */
`timescale 1ns/10ps
module bcltd_bitop
(
	input wire logic [1:0] op,
	input wire logic [2:0] idx,
	input wire logic [7:0] latch_val,
	input wire logic [7:0] pin_val,
	input wire logic is_port,
	output logic [7:0] res,
	output logic bit_val
);
	logic [7:0] src;
	logic [7:0] mask;
	always_comb
	begin
		src = is_port ? pin_val : latch_val;
		mask = 8'h01 << idx;
		bit_val = src[idx];
		case (bcltd_pkg::bcltd_bitop_t'(op))
			bcltd_pkg::BCL_CLR: res = src & ~mask;
			bcltd_pkg::BCL_SET: res = src | mask;
			bcltd_pkg::BCL_TOG: res = src ^ mask;
			default: res = src;
		endcase
	end
endmodule

/* File: test/bcltd_props.sv */
`timescale 1ns/10ps
module bcltd_props
(
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic [15:0] INSTR,
	input wire logic INSTR_VALID,
	input wire logic [7:0] FILE_ADDR,
	input wire logic FILE_WE,
	input wire logic PC_LOAD,
	input wire logic [20:0] PC_TARGET,
	input wire logic PC_REL,
	input wire logic SKIP,
	input wire logic STALL,
	input wire logic [7:0] WORKING_REGISTER,
	input wire logic [3:0] BANK_SELECT_REGISTER,
	input wire logic TIMEOUT_FLAG,
	input wire logic POWER_DOWN_FLAG,
	input wire logic GLOBAL_INTERRUPT_ENABLE,
	input wire logic PERIPHERAL_LOW_INTERRUPT_ENABLE,
	input wire logic STANDBY,
	input wire logic WATCHDOG_CLEAR,
	input wire logic PRESCALER_CLR
);
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (RST);
	logic rst_d_r;
	logic [15:0] d1_r;
	logic [15:0] d2_r;
	logic [15:0] last_r;
	always_ff @(posedge REF_CLK)
	begin
		rst_d_r <= RST;
		d1_r <= INSTR;
		d2_r <= d1_r;
	end
	// Last taken word, so a second word can be told from a lone one
	always_ff @(posedge REF_CLK)
	begin
		if (RST)
			last_r <= 16'h0000;
		else if (INSTR_VALID)
			last_r <= INSTR;
	end
	sequence s_goto_pair;
		INSTR_VALID && INSTR[15:8] == 8'hef ##1
			INSTR_VALID && INSTR[15:12] == 4'hf;
	endsequence
	sequence s_lone_sec;
		INSTR_VALID && INSTR[15:12] == 4'hf && last_r[15:10] != 6'b111011;
	endsequence
	property p_reset_vals;
		rst_d_r |-> TIMEOUT_FLAG && POWER_DOWN_FLAG && !PC_LOAD &&
			WORKING_REGISTER == 8'h00;
	endproperty
	property p_load_once;
		PC_LOAD |=> !PC_LOAD;
	endproperty
	property p_load_stall;
		PC_LOAD |-> STALL;
	endproperty
	property p_rel_stall;
		PC_REL && INSTR_VALID |=> STALL;
	endproperty
	property p_goto_target;
		s_goto_pair |=> !PC_LOAD || PC_TARGET == {d1_r[11:0], d2_r[7:0], 1'b0};
	endproperty
	property p_lone_sec;
		s_lone_sec |=> $stable(WORKING_REGISTER) && !PC_LOAD;
	endproperty
	property p_lit_move;
		INSTR_VALID && INSTR[15:8] == 8'h0e |=>
			SKIP || STALL || WORKING_REGISTER == d1_r[7:0];
	endproperty
	property p_bank_load;
		INSTR_VALID && INSTR[15:4] == 12'h010 |=>
			SKIP || STALL || BANK_SELECT_REGISTER == d1_r[3:0];
	endproperty
	property p_standby;
		STANDBY |-> TIMEOUT_FLAG && !POWER_DOWN_FLAG;
	endproperty
	property p_wdt;
		WATCHDOG_CLEAR |-> TIMEOUT_FLAG && POWER_DOWN_FLAG;
	endproperty
	property p_int_ret;
		$rose(GLOBAL_INTERRUPT_ENABLE) |-> PERIPHERAL_LOW_INTERRUPT_ENABLE;
	endproperty
	property p_presc;
		PRESCALER_CLR |-> FILE_WE && FILE_ADDR == bcltd_pkg::TIMER_ZERO_COUNTER_ADDR;
	endproperty
	a_reset_vals: assert property (p_reset_vals)
		else $error("bad state after reset");
	a_load_once: assert property (p_load_once)
		else $error("jump load held two cycles");
	a_load_stall: assert property (p_load_stall)
		else $error("jump load without idle slot");
	a_rel_stall: assert property (p_rel_stall)
		else $error("relative jump without idle slot");
	a_goto_target: assert property (p_goto_target)
		else $error("jump target wrong");
	a_lone_sec: assert property (p_lone_sec)
		else $error("lone second word had an effect");
	a_lit_move: assert property (p_lit_move)
		else $error("literal move wrong");
	a_bank_load: assert property (p_bank_load)
		else $error("bank load wrong");
	a_standby: assert property (p_standby)
		else $error("standby flags wrong");
	a_wdt: assert property (p_wdt)
		else $error("watchdog clear flags wrong");
	a_int_ret: assert property (p_int_ret)
		else $error("interrupt return enables wrong");
	a_presc: assert property (p_presc)
		else $error("prescaler clear without timer write");
endmodule

/* File: test/bcltd_pmem.sv */
`timescale 1ns/10ps
module bcltd_pmem
(
	input wire logic clk,
	input wire logic rst,
	output logic [15:0] word,
	output logic valid
);
	logic [15:0] q[$];
	task automatic put(input logic [15:0] w);
		q.push_back(w);
	endtask
	initial
	begin
		word = 16'h0000;
		valid = 1'b0;
	end
	// Idle bus shows the inverted word so stale data never looks fresh
	always @(posedge clk)
	begin
		if (!rst && q.size() > 0)
		begin
			word <= q.pop_front();
			valid <= 1'b1;
		end
		else
		begin
			word <= ~word;
			valid <= 1'b0;
		end
	end
endmodule

/* File: test/bcltd_tb.sv */
`timescale 1ns/10ps
module bcltd_tb;
	logic REF_CLK, RST, INSTR_VALID, PRESCALER_TO_TIMER_ZERO_COUNTER;
	logic [15:0] INSTR, PRODUCT, seen;
	logic [7:0] FILE_RDATA, PORT_PINS, FILE_ADDR, FILE_WDATA, WORKING_REGISTER;
	logic [7:0] wd, wa, pw;
	logic ab;
	logic [20:0] PC_TARGET;
	logic [10:0] PC_OFFSET;
	logic [3:0] BANK_SELECT_REGISTER;
	logic [1:0] PTR_SEL, TBL_MODE;
	logic [11:0] INDIRECT_POINTER;
	logic [4:0] flg;
	logic FILE_ACCESS_BANK, FILE_WE, PRESCALER_CLR, PC_LOAD, PC_REL, SKIP;
	logic STALL, STACK_PUSH, STACK_POP, FAST_SAVE, FAST_RESTORE, PTR_LOAD;
	logic TBL_READ, TBL_WRITE, CARRY_FLAG, DIGIT_CARRY_FLAG, ZERO_FLAG;
	logic OVERFLOW_FLAG, NEGATIVE_FLAG, TIMEOUT_FLAG, POWER_DOWN_FLAG;
	logic GLOBAL_INTERRUPT_ENABLE, PERIPHERAL_LOW_INTERRUPT_ENABLE;
	logic WATCHDOG_CLEAR, STANDBY, SOFT_RESET;
	int bad_count, tests_run;
	assign flg = {CARRY_FLAG, DIGIT_CARRY_FLAG, ZERO_FLAG, OVERFLOW_FLAG,
		NEGATIVE_FLAG};
	bcltd_top bcltd_top_inst (.REF_CLK, .RST, .INSTR, .INSTR_VALID,
		.FILE_RDATA, .PORT_PINS, .PRESCALER_TO_TIMER_ZERO_COUNTER, .FILE_ADDR,
		.FILE_ACCESS_BANK, .FILE_WDATA, .FILE_WE, .PRESCALER_CLR, .PC_LOAD,
		.PC_TARGET, .PC_REL, .PC_OFFSET, .SKIP, .STALL, .STACK_PUSH,
		.STACK_POP, .FAST_SAVE, .FAST_RESTORE, .WORKING_REGISTER,
		.BANK_SELECT_REGISTER, .PTR_SEL, .INDIRECT_POINTER, .PTR_LOAD,
		.TBL_READ, .TBL_WRITE, .TBL_MODE, .PRODUCT, .CARRY_FLAG,
		.DIGIT_CARRY_FLAG, .ZERO_FLAG, .OVERFLOW_FLAG, .NEGATIVE_FLAG,
		.TIMEOUT_FLAG, .POWER_DOWN_FLAG, .GLOBAL_INTERRUPT_ENABLE,
		.PERIPHERAL_LOW_INTERRUPT_ENABLE, .WATCHDOG_CLEAR, .STANDBY,
		.SOFT_RESET);
	bcltd_pmem bcltd_pmem_inst (.clk(REF_CLK), .rst(RST), .word(INSTR),
		.valid(INSTR_VALID));
	initial
	begin
		REF_CLK = 1'b0;
		forever #5 REF_CLK = ~REF_CLK;
	end
	task automatic test_done;
		$display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Pulses are gathered over a window, as effects may land a slot late
	task automatic run(input int n);
		seen = 16'h0000;
		repeat (n)
		begin
			@(negedge REF_CLK);
			seen |= {PC_LOAD, PC_REL, SKIP, FILE_WE, PRESCALER_CLR, PTR_LOAD,
				FAST_SAVE, SOFT_RESET, STALL, STACK_PUSH, STACK_POP,
				FAST_RESTORE, WATCHDOG_CLEAR, STANDBY, TBL_READ, TBL_WRITE};
			if (FILE_WE === 1'b1)
			begin
				wd = FILE_WDATA;
				wa = FILE_ADDR;
				ab = FILE_ACCESS_BANK;
			end
		end
	endtask
	task automatic op(input logic [15:0] a, input logic [15:0] b = 16'h0000,
		input logic [15:0] c = 16'h0000, input int k = 1);
		bcltd_pmem_inst.put(a);
		if (k > 1)
			bcltd_pmem_inst.put(b);
		if (k > 2)
			bcltd_pmem_inst.put(c);
		run(4 + k);
	endtask
	task automatic t_lit;
		logic [15:0] w [10] = '{16'h0e10, 16'h0f15, 16'h0bf0, 16'h0a20,
			16'h0980, 16'h0801, 16'h0e03, 16'h0d05, 16'h0e0a, 16'h0007};
		logic [12:0] e [10] = '{{8'h10, 5'h00}, {8'h25, 5'h00},
			{8'h20, 5'h00}, {8'h00, 5'h04}, {8'h80, 5'h01}, {8'h81, 5'h0b},
			{8'h03, 5'h0b}, {8'h03, 5'h0b}, {8'h0a, 5'h0b}, {8'h10, 5'h0b}};
		for (int i = 0; i < 10; i++)
		begin
			op(w[i]);
			chk({WORKING_REGISTER, flg}, e[i]);
		end
		chk(PRODUCT, 16'h000f);
		op(16'h0107);
		chk(BANK_SELECT_REGISTER, 4'h7);
	endtask
	// Flags stand at C0 DC1 Z0 OV1 N1 here, so taken codes are 0x5a
	task automatic t_br;
		logic [7:0] tk = 8'h5a;
		for (int i = 0; i < 8; i++)
		begin
			pw = WORKING_REGISTER;
			op({5'h1c, i[2:0], 8'hfe}, {12'h0e5, i[3:0]}, 16'h0000, 2);
			chk({seen[14], seen[7], WORKING_REGISTER},
				{tk[i], tk[i], tk[i] ? pw : {4'h5, i[3:0]}});
			if (tk[i])
				chk(PC_OFFSET, 11'h7fe);
		end
		for (int i = 0; i < 2; i++)
		begin
			op({4'hd, i[0], 11'h005}, 16'h0000, 16'h0000, 2);
			chk({seen[14], seen[7], seen[6], PC_OFFSET},
				{2'b11, i[0], 11'h005});
		end
	endtask
	task automatic t_jmp;
		op(16'hef12, 16'hf345, 16'h0000, 2);
		chk({seen[15], seen[7], PC_TARGET}, {2'b11, 12'h345, 8'h12, 1'b0});
		op(16'hed34, 16'hf001, 16'h0000, 2);
		chk({seen[15], seen[9], seen[6], PC_TARGET},
			{3'b111, 12'h001, 8'h34, 1'b0});
		pw = WORKING_REGISTER;
		op(16'hf0ee);
		chk({seen, WORKING_REGISTER}, {16'h0000, pw});
		op(16'hee2a, 16'hf0bc, 16'h0000, 2);
		chk({seen[10], PTR_SEL, INDIRECT_POINTER}, {3'b110, 12'habc});
	endtask
	task automatic t_skip;
		pw = WORKING_REGISTER;
		op(16'hb210, 16'h0e33, 16'h0000, 2);
		chk({seen[13], WORKING_REGISTER}, {1'b1, pw});
		op(16'ha010, 16'hef12, 16'hf345, 3);
		chk({seen[13], seen[15], WORKING_REGISTER}, {2'b10, pw});
		op(16'hb010, 16'h0e33, 16'h0000, 2);
		chk({seen[13], WORKING_REGISTER}, {1'b0, 8'h33});
	endtask
	task automatic t_bit;
		logic [15:0] w [5] = '{16'h8620, 16'h9020, 16'h7f20, 16'h8281,
			16'h80d6};
		logic [17:0] e [5] = '{{2'b10, 8'h20, 8'h09}, {2'b10, 8'h20, 8'h00},
			{2'b10, 8'h20, 8'h81}, {2'b10, 8'h81, 8'hf2},
			{2'b11, 8'hd6, 8'h01}};
		for (int i = 0; i < 5; i++)
		begin
			op(w[i]);
			chk({seen[12], seen[11], wa, wd}, e[i]);
		end
		@(posedge REF_CLK);
		PRESCALER_TO_TIMER_ZERO_COUNTER <= 1'b0;
		@(negedge REF_CLK);
		op(16'h81d6);
		chk({seen[12], seen[11], ab, wa, wd}, {3'b101, 8'hd6, 8'h01});
	endtask
	task automatic t_inh;
		logic [15:0] w [7] = '{16'h0004, 16'h0005, 16'h0006, 16'h0013,
			16'h0011, 16'h0c77, 16'h0000};
		logic [7:0] e [7] = '{8'h08, 8'h40, 8'h20, 8'hb0, 8'hb0, 8'ha0, 8'h00};
		op(16'h0003, 16'h0000, 16'h0000, 2);
		chk({seen[7:0], TIMEOUT_FLAG, POWER_DOWN_FLAG}, {8'h04, 2'b10});
		for (int i = 0; i < 7; i++)
		begin
			op(w[i], 16'h0000, 16'h0000, 2);
			chk(seen[7:0], e[i]);
		end
		chk({TIMEOUT_FLAG, POWER_DOWN_FLAG, GLOBAL_INTERRUPT_ENABLE,
			PERIPHERAL_LOW_INTERRUPT_ENABLE, WORKING_REGISTER},
			{4'hf, 8'h77});
		for (int i = 0; i < 8; i++)
		begin
			op({12'h000, 4'h8 + i[3:0]}, 16'h0000, 16'h0000, 2);
			chk({seen[7:0], TBL_MODE},
				{i < 4 ? 8'h82 : 8'h81, i[1:0]});
		end
		op(16'h00ff);
		chk({seen[8], WORKING_REGISTER, GLOBAL_INTERRUPT_ENABLE}, 10'h200);
	endtask
	initial
	begin
		#200000;
		bad_count++;
		test_done();
	end
	initial
	begin
		RST = 1'b1;
		FILE_RDATA = 8'h01;
		PORT_PINS = 8'hf0;
		PRESCALER_TO_TIMER_ZERO_COUNTER = 1'b1;
		bad_count = 0;
		tests_run = 0;
		repeat (2) @(posedge REF_CLK);
		RST <= 1'b0;
		@(negedge REF_CLK);
		chk({TIMEOUT_FLAG, POWER_DOWN_FLAG, WORKING_REGISTER, flg,
			GLOBAL_INTERRUPT_ENABLE}, {2'b11, 14'h0000});
		t_lit();
		t_br();
		t_jmp();
		t_skip();
		t_bit();
		t_inh();
		test_done();
	end
endmodule
bind bcltd_top bcltd_props bcltd_props_inst (.REF_CLK, .RST, .INSTR,
	.INSTR_VALID, .FILE_ADDR, .FILE_WE, .PC_LOAD, .PC_TARGET, .PC_REL, .SKIP,
	.STALL, .WORKING_REGISTER, .BANK_SELECT_REGISTER, .TIMEOUT_FLAG,
	.POWER_DOWN_FLAG, .GLOBAL_INTERRUPT_ENABLE,
	.PERIPHERAL_LOW_INTERRUPT_ENABLE, .STANDBY, .WATCHDOG_CLEAR,
	.PRESCALER_CLR);
